// File: inc/i2c_target_pkg.sv
package i2c_target_pkg;

    // ----------------------------------------------------------------
    // Bus address and word address space
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h6e;
    localparam logic [6:0] ADDR_STRAP_LOW = 7'h6a;
    localparam logic [2:0] WORD_ADDR_LAST = 3'h7;
    localparam logic [2:0] WORD_ADDR_STEP = 3'h1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_CONTROL = 3'h0;
    localparam logic [2:0] REG_IRQ_STATUS = 3'h1;
    localparam logic [2:0] REG_POWER_STATUS = 3'h2;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_ID_SWITCH = 0;
    localparam int CTRL_MIC_PATH = 1;
    localparam int CTRL_IRQ_POL = 2;
    localparam int CTRL_SOFT_RESET = 7;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h87;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int IRQ_ID_DONE = 0;
    localparam int IRQ_PORT_DONE = 1;
    localparam int IRQ_W = 2;
    localparam int PWR_BUS_PRESENT = 0;
    localparam int PWR_CRADLE_PRESENT = 1;
    localparam int PWR_BUS_OVERCURRENT = 2;
    localparam int PWR_CRADLE_OVERCURRENT = 3;

    // ----------------------------------------------------------------
    // Link state machine and byte kinds
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_RX_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_TX_ACK = 5'h10
    } link_state_t;

    typedef enum logic [2:0] {
        BYTE_DEV = 3'h1,
        BYTE_WORD = 3'h2,
        BYTE_DATA = 3'h4
    } byte_kind_t;

endpackage : i2c_target_pkg

// File: inc/irq_link_if.sv
interface irq_link_if;
    logic [1:0] events;
    logic clrToggle;
    logic [1:0] clrMask;
    logic polarity;
    logic rst;
    logic [1:0] flags;
    logic pinOe;

    modport core (
        output events, clrToggle, clrMask, polarity, rst,
        input flags, pinOe
    );
    modport irq (
        input events, clrToggle, clrMask, polarity, rst,
        output flags, pinOe
    );
endinterface : irq_link_if

// File: src/pin_sync.sv
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins in, filtered levels out
    input wire logic [W-1:0] pins,
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;

    sync_t s;
    sync_t next_s;

    // A bit changes only once the second and third stages agree.
    always_comb begin
        next_s = s;
        next_s.s1 = pins;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < W; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.q[i] = s.s3[i];
            end
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= {INIT, INIT, INIT, INIT};
        end else begin
            s <= next_s;
        end
    end

    assign level = s.q;

endmodule : pin_sync

// File: src/irq_ctrl.sv
module irq_ctrl (
    // Clock
    input wire logic clk,
    // Core side
    irq_link_if.irq io
);
    typedef struct packed {
        logic clrS1;
        logic clrS2;
        logic clrS3;
        logic clrS4;
        logic [1:0] maskS1;
        logic [1:0] maskS2;
        logic [1:0] flags;
        logic oe;
    } irq_state_t;

    irq_state_t s;
    irq_state_t next_s;
    logic clearNow;

    // The clear toggle is edge detected one stage late so the mask has settled.
    always_comb begin
        next_s = s;
        next_s.clrS1 = io.clrToggle;
        next_s.clrS2 = s.clrS1;
        next_s.clrS3 = s.clrS2;
        next_s.clrS4 = s.clrS3;
        next_s.maskS1 = io.clrMask;
        next_s.maskS2 = s.maskS1;
        clearNow = s.clrS3 ^ s.clrS4;
        next_s.flags = (s.flags & ~(clearNow ? s.maskS2 : 2'h0)) | io.events;
        next_s.oe = (|next_s.flags) ^ io.polarity;
    end

    // State register, cleared by the merged reset.
    always_ff @(posedge clk) begin
        if (io.rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign io.flags = s.flags;
    assign io.pinOe = s.oe;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    event_sets_flag_a:
    assert property (@(posedge clk) disable iff (io.rst)
        io.events[0] |=> s.flags[0])
    else $error("Detection event did not set its flag.");

    flag_holds_a:
    assert property (@(posedge clk) disable iff (io.rst)
        s.flags[1] && !clearNow |=> s.flags[1])
    else $error("Pending flag dropped without a clear.");

    pin_low_pending_a:
    assert property (@(posedge clk) disable iff (io.rst)
        (|s.flags) && !io.polarity && $stable(io.polarity) |-> s.oe)
    else $error("Pin not pulled low while pending.");

    pin_inverted_a:
    assert property (@(posedge clk) disable iff (io.rst)
        !(|s.flags) && io.polarity && $stable(io.polarity) |-> s.oe)
    else $error("Inverted polarity did not hold pin low when idle.");

endmodule : irq_ctrl

// File: src/i2c_target_irq_reset_ctrl.sv
// Operation
// - Register bit switches ID to control bus
// - Detection completions raise the interrupt
// - Open-drain pin pulls low while pending
// - Polarity bit 1 inverts pin drive
// - Supply presence readable in status register
// - Over-current per power path readable
// - Mic path closes only above undervoltage
// - Any reset source clears everything
// - Power-on reset until any lockout clears
// - High reset pin holds device reset
// - Software reset bit reinitialises device
// - START and STOP framed by SDA edges
// - STOP during read returns to idle
// - STOP during write suspends until START
// - Sample data while SCL is high
// - Bytes acknowledged in ninth clock
// - Next byte only after host acknowledge
// - Strap picks address, others ignored
// - Word address increments, wraps after seven
module i2c_target_irq_reset_ctrl (
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial link
    input wire logic linkClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic busAddrStrap,
    // Reset sources
    input wire logic hwResetPin,
    input wire logic coreSupplyOk,
    input wire logic busUndervoltageLockout,
    input wire logic cradleUndervoltageLockout,
    input wire logic batteryUndervoltageLockout,
    // Power status
    input wire logic busPowerPresentPin,
    input wire logic cradlePowerPresentPin,
    input wire logic busOvercurrentGuard,
    input wire logic cradleOvercurrentGuard,
    // Detection events
    input wire logic idDetectDone,
    input wire logic portDetectDone,
    // Switches and interrupt pin
    output logic linkCtrlBusPinSwitch,
    output logic microphonePathPinSwitch,
    output logic irqOutPinOut,
    output logic irqOutPinOe
);
    // ----------------------------------------------------------------
    // System clock domain
    // ----------------------------------------------------------------
    typedef struct packed {
        logic rstAll;
        logic [3:0] ctlS1;
        logic [3:0] ctlS2;
        logic linkSwitch;
        logic micSwitch;
    } sys_state_t;

    sys_state_t c;
    sys_state_t next_c;
    logic porRst;
    logic [4:0] sysPins;
    logic hwRst;
    logic porHold;
    logic busUvlo;
    logic [7:0] ctrlReg;

    irq_link_if irqBus ();

    assign porRst = !resetn;

    // Reset and supply pins are asynchronous to this clock.
    pin_sync #(
        .W(5),
        .INIT(5'h00)
    ) sysSync (
        .clk(clk),
        .rst(porRst),
        .pins({hwResetPin, coreSupplyOk, busUndervoltageLockout,
            cradleUndervoltageLockout, batteryUndervoltageLockout}),
        .level(sysPins)
    );

    assign hwRst = sysPins[4];
    assign busUvlo = sysPins[2];
    assign porHold = !sysPins[3] || (sysPins[2] && sysPins[1] && sysPins[0]);

    // Merge resets; the control levels arrive from the link domain by 2FF.
    always_comb begin
        next_c = c;
        next_c.ctlS1 = {ctrlReg[i2c_target_pkg::CTRL_SOFT_RESET],
            ctrlReg[i2c_target_pkg::CTRL_IRQ_POL],
            ctrlReg[i2c_target_pkg::CTRL_MIC_PATH],
            ctrlReg[i2c_target_pkg::CTRL_ID_SWITCH]};
        next_c.ctlS2 = c.ctlS1;
        next_c.rstAll = porHold || hwRst || c.ctlS2[3];
        if (c.rstAll) begin
            next_c.linkSwitch = 1'b0;
            next_c.micSwitch = 1'b0;
        end else begin
            next_c.linkSwitch = c.ctlS2[0];
            next_c.micSwitch = c.ctlS2[1] && !busUvlo;
        end
    end

    // The merged reset is set by the power-on input and clears once no reset source holds it.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            c <= '{rstAll: 1'b1, default: '0};
        end else begin
            c <= next_c;
        end
    end

    // Interrupt block runs on the system clock, reset by the merged reset.
    assign irqBus.events = {portDetectDone, idDetectDone};
    assign irqBus.polarity = c.ctlS2[2];
    assign irqBus.rst = c.rstAll;

    irq_ctrl irqUnit (
        .clk(clk),
        .io(irqBus.irq)
    );

    assign linkCtrlBusPinSwitch = c.linkSwitch;
    assign microphonePathPinSwitch = c.micSwitch;
    assign irqOutPinOut = 1'b0;
    assign irqOutPinOe = irqBus.pinOe;

    // ----------------------------------------------------------------
    // Link clock domain
    // ----------------------------------------------------------------
    typedef struct packed {
        i2c_target_pkg::link_state_t st;
        i2c_target_pkg::byte_kind_t kind;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [2:0] wordAddr;
        logic isRead;
        logic ackSeen;
        logic sdaOe;
        logic [7:0] ctrl;
        logic [1:0] clrMask;
        logic clrToggle;
        logic [1:0] flagS1;
        logic [1:0] flagS2;
        logic sclPrev;
        logic sdaPrev;
    } link_state_t;

    link_state_t l;
    link_state_t next_l;
    logic linkRstS1;
    logic linkRst;
    logic [6:0] linkPins;
    logic sclS;
    logic sdaS;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic addrMiss;
    logic doLoad;
    logic [6:0] devAddr;
    logic [7:0] readByte;

    // The clear request travels to the interrupt block as a toggle with its mask.
    assign irqBus.clrToggle = l.clrToggle;
    assign irqBus.clrMask = l.clrMask;

    // Merged reset reaches the link logic through two flip-flops.
    always_ff @(posedge linkClk) begin
        linkRstS1 <= c.rstAll;
        linkRst <= linkRstS1;
    end

    // Bus lines idle high, strap and status pins idle low until sampled.
    pin_sync #(
        .W(7),
        .INIT(7'h60)
    ) linkSync (
        .clk(linkClk),
        .rst(linkRst),
        .pins({sclIn, sdaIn, busAddrStrap, cradleOvercurrentGuard,
            busOvercurrentGuard, cradlePowerPresentPin, busPowerPresentPin}),
        .level(linkPins)
    );

    assign sclS = linkPins[6];
    assign sdaS = linkPins[5];
    assign ctrlReg = l.ctrl;

    assign devAddr = linkPins[4] ? i2c_target_pkg::ADDR_STRAP_HIGH
        : i2c_target_pkg::ADDR_STRAP_LOW;

    // Read data mux; unused word addresses read as zero.
    always_comb begin
        readByte = 8'h00;
        case (l.wordAddr)
            i2c_target_pkg::REG_CONTROL: begin
                readByte = l.ctrl;
            end
            i2c_target_pkg::REG_IRQ_STATUS: begin
                readByte = {6'h00, l.flagS2};
            end
            i2c_target_pkg::REG_POWER_STATUS: begin
                readByte = {4'h0, linkPins[3:0]};
            end
            default: begin
                readByte = 8'h00;
            end
        endcase
    end

    // Byte engine; drive changes follow a falling SCL edge, except the release on START or STOP.
    always_comb begin
        next_l = l;
        doLoad = 1'b0;
        next_l.sclPrev = sclS;
        next_l.sdaPrev = sdaS;
        next_l.flagS1 = irqBus.flags;
        next_l.flagS2 = l.flagS1;
        sclRise = sclS && !l.sclPrev;
        sclFall = !sclS && l.sclPrev;
        startSeen = sclS && l.sclPrev && l.sdaPrev && !sdaS;
        stopSeen = sclS && l.sclPrev && !l.sdaPrev && sdaS;
        addrMiss = l.shift[7:1] != devAddr;
        case (l.st)
            i2c_target_pkg::ST_IDLE: begin
                next_l.sdaOe = 1'b0;
            end
            i2c_target_pkg::ST_RX: begin
                if (sclRise) begin
                    next_l.shift = {l.shift[6:0], sdaS};
                    next_l.bitCnt = l.bitCnt + 4'h1;
                end else if (sclFall && l.bitCnt == i2c_target_pkg::BITS_PER_BYTE) begin
                    next_l.bitCnt = 4'h0;
                    next_l.st = i2c_target_pkg::ST_RX_ACK;
                    next_l.sdaOe = 1'b1;
                    case (l.kind)
                        i2c_target_pkg::BYTE_DEV: begin
                            if (addrMiss) begin
                                next_l.st = i2c_target_pkg::ST_IDLE;
                                next_l.sdaOe = 1'b0;
                            end
                            next_l.isRead = l.shift[0];
                        end
                        i2c_target_pkg::BYTE_WORD: begin
                            next_l.wordAddr = l.shift[2:0];
                        end
                        default: begin
                            if (l.wordAddr == i2c_target_pkg::REG_CONTROL) begin
                                next_l.ctrl = l.shift & i2c_target_pkg::CTRL_WRITE_MASK;
                            end
                            next_l.wordAddr = l.wordAddr + i2c_target_pkg::WORD_ADDR_STEP;
                        end
                    endcase
                end
            end
            i2c_target_pkg::ST_RX_ACK: begin
                if (sclFall) begin
                    next_l.sdaOe = 1'b0;
                    if (l.isRead) begin
                        doLoad = 1'b1;
                    end else begin
                        next_l.st = i2c_target_pkg::ST_RX;
                        next_l.kind = (l.kind == i2c_target_pkg::BYTE_DEV)
                            ? i2c_target_pkg::BYTE_WORD : i2c_target_pkg::BYTE_DATA;
                    end
                end
            end
            i2c_target_pkg::ST_TX: begin
                if (sclRise) begin
                    next_l.bitCnt = l.bitCnt + 4'h1;
                end else if (sclFall) begin
                    if (l.bitCnt == i2c_target_pkg::BITS_PER_BYTE) begin
                        next_l.bitCnt = 4'h0;
                        next_l.sdaOe = 1'b0;
                        next_l.ackSeen = 1'b0;
                        next_l.st = i2c_target_pkg::ST_TX_ACK;
                    end else begin
                        next_l.shift = {l.shift[6:0], 1'b0};
                        next_l.sdaOe = !l.shift[6];
                    end
                end
            end
            i2c_target_pkg::ST_TX_ACK: begin
                if (sclRise) begin
                    next_l.ackSeen = !sdaS;
                end else if (sclFall && l.ackSeen) begin
                    doLoad = 1'b1;
                end
            end
            default: begin
                next_l.st = i2c_target_pkg::ST_IDLE;
            end
        endcase
        // Loading a byte advances the word address; reading status clears it.
        if (doLoad) begin
            next_l.st = i2c_target_pkg::ST_TX;
            next_l.shift = readByte;
            next_l.sdaOe = !readByte[7];
            next_l.bitCnt = 4'h0;
            next_l.wordAddr = l.wordAddr + i2c_target_pkg::WORD_ADDR_STEP;
            if (l.wordAddr == i2c_target_pkg::REG_IRQ_STATUS) begin
                next_l.clrMask = l.flagS2;
                next_l.clrToggle = !l.clrToggle;
            end
        end
        if (startSeen) begin
            next_l.st = i2c_target_pkg::ST_RX;
            next_l.kind = i2c_target_pkg::BYTE_DEV;
            next_l.bitCnt = 4'h0;
            next_l.sdaOe = 1'b0;
        end else if (stopSeen) begin
            next_l.st = i2c_target_pkg::ST_IDLE;
            next_l.sdaOe = 1'b0;
        end
    end

    // Link state register.
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            l <= '{st: i2c_target_pkg::ST_IDLE, kind: i2c_target_pkg::BYTE_DEV,
                ctrl: i2c_target_pkg::CTRL_RESET, sclPrev: 1'b1, sdaPrev: 1'b1,
                default: '0};
        end else begin
            l <= next_l;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = l.sdaOe;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    hw_reset_hold_a:
    assert property (@(posedge clk) disable iff (!resetn)
        hwRst |=> c.rstAll)
    else $error("Reset pin high did not hold reset.");

    por_hold_a:
    assert property (@(posedge clk) disable iff (!resetn)
        porHold |=> c.rstAll ##1 !c.linkSwitch)
    else $error("Lockout did not hold reset.");

    mic_undervoltage_lockout_a:
    assert property (@(posedge clk) disable iff (!resetn)
        busUvlo |=> !c.micSwitch)
    else $error("Mic path closed under lockout.");

    soft_reset_a:
    assert property (@(posedge clk) disable iff (!resetn)
        $rose(c.ctlS2[3]) |-> ##1 c.rstAll)
    else $error("Software reset bit did not reset.");

    stop_idle_a:
    assert property (@(posedge linkClk) disable iff (linkRst)
        stopSeen && !startSeen |=> l.st == i2c_target_pkg::ST_IDLE && !l.sdaOe)
    else $error("STOP did not return the link to idle.");

    addr_miss_a:
    assert property (@(posedge linkClk) disable iff (linkRst)
        l.st == i2c_target_pkg::ST_RX && l.kind == i2c_target_pkg::BYTE_DEV
        && sclFall && l.bitCnt == 4'h8 && addrMiss && !stopSeen
        |=> l.st == i2c_target_pkg::ST_IDLE)
    else $error("Foreign address was not ignored.");

    word_wrap_a:
    assert property (@(posedge linkClk) disable iff (linkRst)
        doLoad && l.wordAddr == i2c_target_pkg::WORD_ADDR_LAST && !startSeen
        |=> l.wordAddr == 3'h0)
    else $error("Word address did not wrap to zero.");

    ack_drive_a:
    assert property (@(posedge linkClk) disable iff (linkRst)
        l.st == i2c_target_pkg::ST_RX_ACK |-> l.sdaOe)
    else $error("Acknowledge slot not driven low.");

    no_ack_wait_a:
    assert property (@(posedge linkClk) disable iff (linkRst)
        l.st == i2c_target_pkg::ST_TX_ACK && sclFall && !l.ackSeen
        && !startSeen && !stopSeen |=> l.st == i2c_target_pkg::ST_TX_ACK && !l.sdaOe)
    else $error("Device drove data without acknowledge.");

endmodule : i2c_target_irq_reset_ctrl

// File: sim/i2c_host_model.sv
module i2c_host_model (
    // Wire levels
    input wire logic devPull,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Bus controller
    // ------------------------------------------------------------
    logic hostPull = 1'b0;
    // The pull-up holds the wire high unless a party pulls it low.
    assign sda = !(hostPull | devPull);
    initial scl = 1'b1;
    task automatic start();
        hostPull = 1'b0;
        #800 scl = 1'b1;
        #800 hostPull = 1'b1;
        #800 scl = 1'b0;
        #100;
    endtask : start
    task automatic stop();
        hostPull = 1'b1;
        #800 scl = 1'b1;
        #800 hostPull = 1'b0;
        #800;
    endtask : stop
    // change while low
    // The pause after the fall keeps a data change clear of the clock edge.
    task automatic bitx(input logic b, output logic s);
        hostPull = !b;
        #800 scl = 1'b1;
        #400 s = sda;
        #400 scl = 1'b0;
        #100;
    endtask : bitx
    // byte and acknowledge
    // A released data bit lets the device drive; a zero ack bit is taken.
    task automatic xbyte(input logic [7:0] d, input logic ackIt, output logic [7:0] q,
                         output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(!ackIt, ack);
    endtask : xbyte
endmodule : i2c_host_model

// File: sim/i2c_target_irq_reset_ctrl_tb.sv
module i2c_target_irq_reset_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Stimulus and checking
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic linkClk = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b1;
    logic hwRst = 1'b0;
    logic busUv = 1'b0;
    logic idDone = 1'b0;
    logic portDone = 1'b0;
    logic [3:0] pwr = 4'h0;
    logic scl, sda, sdaOe, lcSw, micSw, irqOe;
    logic sdaLvl, irqLvl;
    logic [7:0] q0, q1;
    int errors = 0;
    int check_count = 0;
    wire logic [6:0] dev = strap ? i2c_target_pkg::ADDR_STRAP_HIGH
                                 : i2c_target_pkg::ADDR_STRAP_LOW;
    // The link clock starts at an odd offset so it has no phase tie to clk.
    always #5 clk = !clk;
    initial #37 forever #80 linkClk = !linkClk;
    i2c_target_irq_reset_ctrl u_i2c_target_irq_reset_ctrl (
        .clk(clk), .resetn(resetn), .linkClk(linkClk), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaLvl), .sdaOe(sdaOe), .busAddrStrap(strap), .hwResetPin(hwRst),
        .coreSupplyOk(1'b1), .busUndervoltageLockout(busUv),
        .cradleUndervoltageLockout(1'b0), .batteryUndervoltageLockout(1'b0),
        .busPowerPresentPin(pwr[0]), .cradlePowerPresentPin(pwr[1]),
        .busOvercurrentGuard(pwr[2]), .cradleOvercurrentGuard(pwr[3]),
        .idDetectDone(idDone), .portDetectDone(portDone),
        .linkCtrlBusPinSwitch(lcSw), .microphonePathPinSwitch(micSw),
        .irqOutPinOut(irqLvl), .irqOutPinOe(irqOe));
    i2c_host_model u_i2c_host_model (.devPull(sdaOe), .scl(scl), .sda(sda));
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : check
    // write sequence
    // The word byte ack is judged; a soft reset may cut the later ones short.
    task automatic wr(input logic [6:0] a, input logic [7:0] w, d0, d1, input logic ackExp);
        logic [7:0] q;
        logic k;
        u_i2c_host_model.start();
        u_i2c_host_model.xbyte({a, 1'b0}, 1'b0, q, k);
        check("address ack", {7'h0, !ackExp}, {7'h0, k});
        if (ackExp) begin
            u_i2c_host_model.xbyte(w, 1'b0, q, k);
            check("word ack", 8'h0, {7'h0, k});
            u_i2c_host_model.xbyte(d0, 1'b0, q, k);
            u_i2c_host_model.xbyte(d1, 1'b0, q, k);
        end
        u_i2c_host_model.stop();
    endtask : wr
    task automatic rd(input logic [7:0] w, output logic [7:0] r0, r1);
        logic [7:0] q;
        logic k;
        u_i2c_host_model.start();
        u_i2c_host_model.xbyte({dev, 1'b0}, 1'b0, q, k);
        u_i2c_host_model.xbyte(w, 1'b0, q, k);
        u_i2c_host_model.start();
        u_i2c_host_model.xbyte({dev, 1'b1}, 1'b0, q, k);
        u_i2c_host_model.xbyte(8'hff, 1'b1, r0, k);
        u_i2c_host_model.xbyte(8'hff, 1'b0, r1, k);
        u_i2c_host_model.stop();
    endtask : rd
    task automatic t_switch();
        wr(dev, 8'h00, 8'h03, 8'h00, 1'b1);
        check("switches", 8'h03, {6'h0, micSw, lcSw});
        rd(8'h00, q0, q1);
        check("control", 8'h03, q0);
        @(negedge clk) busUv = 1'b1;
        repeat (8) @(negedge clk);
        check("mic lockout", 8'h0, {7'h0, micSw});
        busUv = 1'b0;
    endtask : t_switch
    task automatic t_addr();
        @(negedge clk) strap = 1'b0;
        #1000;
        wr(i2c_target_pkg::ADDR_STRAP_HIGH, 8'h00, 8'h00, 8'h00, 1'b0);
        wr(dev, 8'h00, 8'h00, 8'h00, 1'b1);
        check("low strap", 8'h0, {6'h0, micSw, lcSw});
        strap = 1'b1;
        #1000;
    endtask : t_addr
    task automatic t_wrap();
        wr(dev, 8'h07, 8'h03, 8'h01, 1'b1);
        check("wrapped write", 8'h01, {6'h0, micSw, lcSw});
        rd(8'h07, q0, q1);
        check("last word", 8'h00, q0);
        check("wrapped read", 8'h01, q1);
    endtask : t_wrap
    task automatic t_irq();
        @(negedge clk) idDone = 1'b1;
        @(negedge clk) idDone = 1'b0;
        repeat (3) @(negedge clk);
        check("irq pending", 8'h1, {7'h0, irqOe});
        check("open drain levels", 8'h0, {6'h0, sdaLvl, irqLvl});
        wr(dev, 8'h00, 8'h04, 8'h00, 1'b1);
        check("irq inverted", 8'h0, {7'h0, irqOe});
        @(negedge clk) pwr = 4'h9;
        portDone = 1'b1;
        @(negedge clk) portDone = 1'b0;
        rd(8'h01, q0, q1);
        check("irq status", 8'h03, q0);
        check("power status", 8'h09, q1);
        check("irq cleared", 8'h1, {7'h0, irqOe});
        wr(dev, 8'h00, 8'h00, 8'h00, 1'b1);
        check("irq idle", 8'h0, {7'h0, irqOe});
    endtask : t_irq
    task automatic t_reset();
        wr(dev, 8'h00, 8'h83, 8'h00, 1'b1);
        #3000;
        rd(8'h00, q0, q1);
        check("soft reset", 8'h00, q0);
        wr(dev, 8'h00, 8'h03, 8'h00, 1'b1);
        @(negedge clk) hwRst = 1'b1;
        repeat (10) @(negedge clk);
        check("pin reset", 8'h0, {6'h0, micSw, lcSw});
        hwRst = 1'b0;
        #3000;
        rd(8'h00, q0, q1);
        check("after pin reset", 8'h00, q0);
    endtask : t_reset
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    // Main sequence after a ten cycle reset.
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk) resetn = 1'b1;
        #3000;
        t_switch();
        t_addr();
        t_wrap();
        t_irq();
        t_reset();
        close_out();
    end
    // A hang is cut short and counted as a mismatch.
    initial begin
        #1000000;
        errors++;
        close_out();
    end
endmodule : i2c_target_irq_reset_ctrl_tb
